// file: logic/cps_alu.sv
// 8-bit alu with status generation
`timescale 1ns/1ps
module cps_alu (
  input  wire logic [cps_pkg::DW-1:0]   a_i,
  input  wire logic [cps_pkg::DW-1:0]   b_i,
  input  wire logic [cps_pkg::ST_W-1:0] st_i,
  input  wire cps_pkg::cps_alu_type     fn_i,
  output logic      [cps_pkg::DW-1:0]   res_o,
  output logic      [cps_pkg::ST_W-1:0] st_o
);
  logic [cps_pkg::DW:0]   sum;
  logic [cps_pkg::DW-1:0] bo;
  logic [4:0]             nib;
  logic                   ci;
  logic                   sub;
  logic                   cin;
  logic [cps_pkg::DW:0]   adj;

  assign cin = st_i[cps_pkg::ST_C];
  assign sub = (fn_i == cps_pkg::FN_SUB) || (fn_i == cps_pkg::FN_SBC);
  assign bo  = sub ? ~b_i : b_i;
  assign ci  = (fn_i == cps_pkg::FN_SUB) ? 1'b1 :
               ((fn_i == cps_pkg::FN_ADC) || (fn_i == cps_pkg::FN_SBC)) ? cin : 1'b0;
  assign sum = {1'b0, a_i} + {1'b0, bo} + {8'h00, ci};
  assign nib = {1'b0, a_i[3:0]} + {1'b0, bo[3:0]} + {4'h0, ci};

  always_comb begin
    adj = {1'b0, a_i};
    if (a_i[3:0] > cps_pkg::BCD_MAX || st_i[cps_pkg::ST_AC]) begin
      adj = adj + {1'b0, cps_pkg::DAA_LO};
    end
    if (adj[7:4] > cps_pkg::BCD_MAX || st_i[cps_pkg::ST_C] || adj[cps_pkg::DW]) begin
      adj = adj + {1'b0, cps_pkg::DAA_HI};
    end
  end

  always_comb begin
    res_o = a_i;
    st_o  = st_i;
    case (fn_i)
      cps_pkg::FN_ADD, cps_pkg::FN_ADC, cps_pkg::FN_SUB, cps_pkg::FN_SBC: begin
        res_o = sum[cps_pkg::DW-1:0];
        st_o[cps_pkg::ST_C]  = sum[cps_pkg::DW];
        st_o[cps_pkg::ST_AC] = nib[4];
        st_o[cps_pkg::ST_OV] = (a_i[7] == bo[7]) && (sum[7] != a_i[7]);
      end
      cps_pkg::FN_DAA: begin
        res_o = adj[cps_pkg::DW-1:0];
        st_o[cps_pkg::ST_C] = adj[cps_pkg::DW] | st_i[cps_pkg::ST_C];
      end
      cps_pkg::FN_AND: res_o = a_i & b_i;
      cps_pkg::FN_OR:  res_o = a_i | b_i;
      cps_pkg::FN_XOR: res_o = a_i ^ b_i;
      cps_pkg::FN_CPL: res_o = ~a_i;
      cps_pkg::FN_RR:  res_o = {a_i[0], a_i[7:1]};
      cps_pkg::FN_RRC: begin
        res_o = {cin, a_i[7:1]};
        st_o[cps_pkg::ST_C] = a_i[0];
      end
      cps_pkg::FN_RL:  res_o = {a_i[6:0], a_i[7]};
      cps_pkg::FN_RLC: begin
        res_o = {a_i[6:0], cin};
        st_o[cps_pkg::ST_C] = a_i[7];
      end
      cps_pkg::FN_INC: res_o = a_i + cps_pkg::ONE_B;
      cps_pkg::FN_DEC: res_o = a_i - cps_pkg::ONE_B;
      cps_pkg::FN_MOV: res_o = b_i;
      default:         res_o = a_i;
    endcase
    st_o[cps_pkg::ST_Z] = (res_o == 8'h00);
  end
endmodule : cps_alu

// file: logic/cps_pkg.sv
// shared constants, types and register map of the program sequencer
package cps_pkg;

  localparam int PC_W    = 12;
  localparam int DW      = 8;
  localparam int IW      = 16;
  localparam int ST_W    = 4;
  localparam int DEPTH   = 8;
  localparam int SP_W    = 3;
  localparam int CNT_W   = 4;

  localparam logic [PC_W-1:0]  RESET_VEC  = 12'h000;
  localparam logic [PC_W-1:0]  INT_VEC    = 12'h004;
  localparam logic [PC_W-1:0]  PC_ONE     = 12'h001;
  localparam logic [CNT_W-1:0] STK_FULL   = 4'h8;
  localparam logic [SP_W-1:0]  SP_ONE     = 3'h1;
  localparam logic [CNT_W-1:0] CNT_ONE    = 4'h1;

  // instruction fields
  localparam int CLS_HI  = 15;
  localparam int CLS_LO  = 13;
  localparam int EXT_BIT = 12;
  localparam int FN_HI   = 11;
  localparam int FN_LO   = 8;
  localparam int INTERRUPT_RETURN_BIT = 0;

  // status bits
  localparam int ST_C  = 0;
  localparam int ST_AC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_OV = 3;

  // decimal adjust
  localparam logic [DW-1:0] DAA_LO  = 8'h06;
  localparam logic [DW-1:0] DAA_HI  = 8'h60;
  localparam logic [3:0]    BCD_MAX = 4'h9;
  localparam logic [DW-1:0] ONE_B   = 8'h01;

  // register byte addresses
  localparam logic [7:0] ADDR_PCL    = 8'h00;
  localparam logic [7:0] ADDR_ACC    = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IPTR   = 8'h0C;
  localparam logic [7:0] ADDR_IDATA  = 8'h10;
  localparam logic [7:0] ADDR_CTRL   = 8'h14;

  // control register bits
  localparam int CTRL_IE     = 0;
  localparam int CTRL_OSC_LO = 1;
  localparam int CTRL_OSC_HI = 2;
  localparam int CTRL_IRQ    = 3;

  typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} cps_phase_type;

  typedef enum logic [1:0] {
    HIGH_SPEED_CRYSTAL_OSC, LOW_SPEED_CRYSTAL_OSC,
    HIGH_SPEED_INTERNAL_RC, LOW_SPEED_INTERNAL_RC
  } cps_osc_type;

  typedef enum logic [3:0] {
    FN_ADD, FN_ADC, FN_SUB, FN_SBC, FN_DAA, FN_AND, FN_OR, FN_XOR,
    FN_CPL, FN_RR, FN_RRC, FN_RL, FN_RLC, FN_INC, FN_DEC, FN_MOV
  } cps_alu_type;

  typedef enum logic [2:0] {
    CL_NOP, CL_ALU, CL_JMP, CL_CALL, CL_RET, CL_SKZ, CL_PCL, CL_RSVD
  } cps_class_type;

endpackage : cps_pkg

// file: logic/cps_seq.sv
// program sequencer core: phases, fetch pipeline, pc, stack, alu, wishbone registers
//
// Overview of operation
// - oscillator source chosen from four; selection driven out from control register.
// - four rotating phases T1 to T4 form one instruction cycle.
// - at T1 the pc increments and the next instruction is fetched.
// - fetch overlaps execution; extended instructions take two cycles.
// - instructions changing the pc cost one extra cycle.
// - branch gets target in one cycle, transfers in a dummy second.
// - pc advances by one per instruction unless control is transferred.
// - jump, call, interrupt and reset load their destination into the pc.
// - a true skip discards the prefetched instruction for a dummy cycle.
// - pc is 12 bits; only the low byte is software visible.
// - writing the low byte jumps within the page and inserts a dummy cycle.
// - eight-level stack of pc values, invisible to software.
// - call and interrupt push the pc; return pops it back.
// - reset sets the stack pointer to entry zero and clears the count, leaving the stack empty.
// - full stack keeps interrupt flag set but withholds acknowledge.
// - call on a full stack still runs and loses the oldest entry.
// - 8-bit alu through the accumulator writes results to registers.
// - alu updates carry, auxiliary, zero and overflow status.
// - alu provides add, subtract, adjust, logic, rotates, inc, dec, skip test.
// - control registers reachable directly and through the indirect pointer; the pointer itself is written only at its direct address.
// - after reset execution starts fetching from address zero.
//
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
module cps_seq (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  input  wire logic [cps_pkg::IW-1:0]   pm_data_i,
  output logic      [cps_pkg::PC_W-1:0] pm_addr_o,
  output logic                          pm_rd_o,
  input  wire logic                     int_req_i,
  output logic                          int_ack_o,
  output logic      [3:0]               phase_o,
  output logic      [1:0]               osc_sel_o
);
  cps_pkg::cps_phase_type   phase_q;
  logic [3:0]               phase_oh_q;
  logic [cps_pkg::PC_W-1:0] pc_q;
  logic [cps_pkg::PC_W-1:0] pm_addr_q;
  logic                     pm_rd_q;
  logic [cps_pkg::IW-1:0]   exec_q;
  logic [cps_pkg::PC_W-1:0] exec_pc_q;
  logic                     exec_v_q;
  logic                     stall_q;
  logic [cps_pkg::DW-1:0]   acc_q;
  logic [cps_pkg::ST_W-1:0] status_q;
  logic [cps_pkg::DW-1:0]   iptr_q;
  logic                     ie_q;
  cps_pkg::cps_osc_type     osc_q;
  logic                     irq_q;
  logic                     int_ack_q;
  logic                     pcl_pend_q;
  logic [cps_pkg::DW-1:0]   pcl_data_q;
  logic                     ack_q;
  logic [31:0]              rdat_q;

  logic                     cyc_end;
  cps_pkg::cps_class_type   ex_cls;
  logic                     ex_go;
  logic                     irq_take;
  logic                     ext_first;
  logic                     do_exec;
  logic                     is_alu;
  logic                     jmp;
  logic                     call;
  logic                     ret;
  logic                     skip;
  logic                     pclw;
  logic                     flush;
  logic [cps_pkg::PC_W-1:0] target;
  logic [cps_pkg::DW-1:0]   alu_res;
  logic [cps_pkg::ST_W-1:0] alu_st;
  logic [cps_pkg::PC_W-1:0] stk_top;
  logic                     stk_full;
  logic                     stk_push;
  logic                     stk_pop;
  logic [cps_pkg::PC_W-1:0] push_d;
  logic [7:0]               eff_adr;
  logic                     bus_wr;
  logic [31:0]              rd_mux;

  // phase sequencer
  assign cyc_end = (phase_q == cps_pkg::PH_T4);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q    <= cps_pkg::PH_T1;
      phase_oh_q <= 4'h1;
    end else begin
      phase_q    <= cps_pkg::cps_phase_type'(phase_q + 2'h1);
      phase_oh_q <= {phase_oh_q[2:0], phase_oh_q[3]};
    end
  end

  // instruction decode of the executing word
  assign ex_cls    = cps_pkg::cps_class_type'(exec_q[cps_pkg::CLS_HI:cps_pkg::CLS_LO]);
  assign is_alu    = (ex_cls == cps_pkg::CL_ALU) || (ex_cls == cps_pkg::CL_SKZ);
  assign irq_take  = exec_v_q && irq_q && ie_q && !stk_full && !pcl_pend_q;
  assign ex_go     = exec_v_q && !irq_take && !pcl_pend_q;
  assign ext_first = ex_go && is_alu && exec_q[cps_pkg::EXT_BIT] && !stall_q;
  assign do_exec   = ex_go && !ext_first;
  assign jmp       = do_exec && (ex_cls == cps_pkg::CL_JMP);
  assign call      = do_exec && (ex_cls == cps_pkg::CL_CALL);
  assign ret       = do_exec && (ex_cls == cps_pkg::CL_RET);
  assign skip      = do_exec && (ex_cls == cps_pkg::CL_SKZ) && alu_st[cps_pkg::ST_Z];
  assign pclw      = do_exec && (ex_cls == cps_pkg::CL_PCL);
  assign flush     = pcl_pend_q || irq_take || jmp || call || ret || skip || pclw;

  always_comb begin
    target = pc_q;
    if (pcl_pend_q) begin
      target = {pc_q[cps_pkg::PC_W-1:cps_pkg::DW], pcl_data_q};
    end else if (irq_take) begin
      target = cps_pkg::INT_VEC;
    end else if (jmp || call) begin
      target = exec_q[cps_pkg::PC_W-1:0];
    end else if (ret) begin
      target = stk_top;
    end else if (pclw) begin
      target = {pc_q[cps_pkg::PC_W-1:cps_pkg::DW], acc_q};
    end
  end

  // return address stack
  assign stk_push = cyc_end && (call || irq_take);
  assign stk_pop  = cyc_end && ret;
  assign push_d   = call ? exec_pc_q + cps_pkg::PC_ONE : exec_pc_q;

  cps_stack u_stack (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .push_i (stk_push),
    .pop_i  (stk_pop),
    .d_i    (push_d),
    .top_o  (stk_top),
    .full_o (stk_full)
  );

  cps_alu u_alu (
    .a_i   (acc_q),
    .b_i   (exec_q[cps_pkg::DW-1:0]),
    .st_i  (status_q),
    .fn_i  (cps_pkg::cps_alu_type'(exec_q[cps_pkg::FN_HI:cps_pkg::FN_LO])),
    .res_o (alu_res),
    .st_o  (alu_st)
  );

  // program counter and fetch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_q      <= cps_pkg::RESET_VEC;
      pm_addr_q <= cps_pkg::RESET_VEC;
      pm_rd_q   <= 1'b0;
    end else begin
      pm_rd_q <= (phase_q == cps_pkg::PH_T1);
      if (phase_q == cps_pkg::PH_T1 && !stall_q) begin
        pm_addr_q <= pc_q;
        pc_q      <= pc_q + cps_pkg::PC_ONE;
      end else if (cyc_end && flush) begin
        pc_q <= target;
      end
    end
  end

  // pipeline register of the executing instruction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exec_q    <= 16'h0000;
      exec_pc_q <= cps_pkg::RESET_VEC;
      exec_v_q  <= 1'b0;
      stall_q   <= 1'b0;
    end else if (cyc_end) begin
      if (flush) begin
        exec_v_q <= 1'b0;
        stall_q  <= 1'b0;
      end else if (ext_first) begin
        stall_q <= 1'b1;
      end else begin
        exec_q    <= pm_data_i;
        exec_pc_q <= pm_addr_q;
        exec_v_q  <= 1'b1;
        stall_q   <= 1'b0;
      end
    end
  end

  // interrupt request flag: set wins over the acknowledge clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q     <= 1'b0;
      int_ack_q <= 1'b0;
    end else begin
      int_ack_q <= cyc_end && irq_take;
      if (int_req_i) begin
        irq_q <= 1'b1;
      end else if (cyc_end && irq_take) begin
        irq_q <= 1'b0;
      end
    end
  end

  // wishbone slave, one wait state, indirect access through the pointer
  assign eff_adr = (wb_adr_i == cps_pkg::ADDR_IDATA) ? iptr_q : wb_adr_i;
  assign bus_wr  = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (eff_adr)
      cps_pkg::ADDR_PCL:    rd_mux[cps_pkg::DW-1:0] = pc_q[cps_pkg::DW-1:0];
      cps_pkg::ADDR_ACC:    rd_mux[cps_pkg::DW-1:0] = acc_q;
      cps_pkg::ADDR_STATUS: rd_mux[cps_pkg::ST_W-1:0] = status_q;
      cps_pkg::ADDR_IPTR:   rd_mux[cps_pkg::DW-1:0] = iptr_q;
      cps_pkg::ADDR_CTRL:   rd_mux[cps_pkg::CTRL_IRQ:0] = {irq_q, osc_q, ie_q};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= wb_cyc_i && wb_stb_i && !ack_q;
      rdat_q <= rd_mux;
    end
  end

  // pending low byte write, taken at the next cycle boundary
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pcl_pend_q <= 1'b0;
      pcl_data_q <= 8'h00;
    end else if (bus_wr && eff_adr == cps_pkg::ADDR_PCL) begin
      pcl_pend_q <= 1'b1;
      pcl_data_q <= wb_dat_i[cps_pkg::DW-1:0];
    end else if (cyc_end) begin
      pcl_pend_q <= 1'b0;
    end
  end

  // accumulator and status; alu result wins over a bus write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q    <= 8'h00;
      status_q <= 4'h0;
    end else if (cyc_end && do_exec && is_alu) begin
      acc_q    <= alu_res;
      status_q <= alu_st;
    end else if (bus_wr && eff_adr == cps_pkg::ADDR_ACC) begin
      acc_q <= wb_dat_i[cps_pkg::DW-1:0];
    end else if (bus_wr && eff_adr == cps_pkg::ADDR_STATUS) begin
      status_q <= wb_dat_i[cps_pkg::ST_W-1:0];
    end
  end

  // pointer and control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      iptr_q <= 8'h00;
      ie_q   <= 1'b0;
      osc_q  <= cps_pkg::HIGH_SPEED_INTERNAL_RC;
    end else begin
      if (bus_wr && wb_adr_i == cps_pkg::ADDR_IPTR) begin
        iptr_q <= wb_dat_i[cps_pkg::DW-1:0];
      end
      if (cyc_end && irq_take) begin
        ie_q <= 1'b0;
      end else if (cyc_end && ret && exec_q[cps_pkg::INTERRUPT_RETURN_BIT]) begin
        ie_q <= 1'b1;
      end else if (bus_wr && eff_adr == cps_pkg::ADDR_CTRL) begin
        ie_q <= wb_dat_i[cps_pkg::CTRL_IE];
      end
      if (bus_wr && eff_adr == cps_pkg::ADDR_CTRL) begin
        osc_q <= cps_pkg::cps_osc_type'(wb_dat_i[cps_pkg::CTRL_OSC_HI:cps_pkg::CTRL_OSC_LO]);
      end
    end
  end

  assign wb_dat_o  = rdat_q;
  assign wb_ack_o  = ack_q;
  assign pm_addr_o = pm_addr_q;
  assign pm_rd_o   = pm_rd_q;
  assign int_ack_o = int_ack_q;
  assign phase_o   = phase_oh_q;
  assign osc_sel_o = osc_q;

  phase_walk_a: assert property (@(posedge clk_i) disable iff (rst_i)
    phase_oh_q[0] |=> phase_oh_q[1] ##1 phase_oh_q[2] ##1 phase_oh_q[3] ##1 phase_oh_q[0])
    else $error("phase clocks out of order");
  pc_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (phase_q == cps_pkg::PH_T1 && !stall_q) |=>
      pc_q == $past(pc_q) + cps_pkg::PC_ONE && pm_addr_q == $past(pc_q))
    else $error("pc not advanced at first phase");
  reset_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> pc_q == cps_pkg::RESET_VEC && !exec_v_q && !stk_full)
    else $error("reset did not restart at address zero");
  jump_dummy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_end && jmp) |=> !exec_v_q && pc_q == $past(exec_q[cps_pkg::PC_W-1:0]) ##4 exec_v_q)
    else $error("jump did not insert one dummy cycle");
  skip_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_end && skip) |=> !exec_v_q)
    else $error("skip kept the prefetched instruction");
  page_jump_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_end && pcl_pend_q) |=>
      pc_q == {$past(pc_q[cps_pkg::PC_W-1:cps_pkg::DW]), $past(pcl_data_q)} && !exec_v_q)
    else $error("low byte write left its page");
  full_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (irq_q && stk_full) |=> irq_q && !int_ack_o)
    else $error("interrupt acknowledged on a full stack");
  ext_two_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_end && ext_first) |=> stall_q [*4] ##1 !stall_q)
    else $error("extended instruction not held for two cycles");
  zero_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_end && do_exec && is_alu) |=> status_q[cps_pkg::ST_Z] == (acc_q == 8'h00))
    else $error("zero flag does not match result");
endmodule : cps_seq

// file: logic/cps_stack.sv
// eight-level return address stack, hidden from software
`timescale 1ns/1ps
module cps_stack (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     push_i,
  input  wire logic                     pop_i,
  input  wire logic [cps_pkg::PC_W-1:0] d_i,
  output logic      [cps_pkg::PC_W-1:0] top_o,
  output logic                          full_o
);
  logic [cps_pkg::PC_W-1:0]  mem_q [cps_pkg::DEPTH];
  logic [cps_pkg::SP_W-1:0]  ptr_q;
  logic [cps_pkg::CNT_W-1:0] cnt_q;

  for (genvar i = 0; i < cps_pkg::DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_i) begin
      if (push_i && ptr_q == cps_pkg::SP_W'(i)) begin
        mem_q[i] <= d_i;
      end
    end
  end

  // pointer wraps on overflow, so the oldest entry is overwritten
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_q <= '0;
      cnt_q <= '0;
    end else if (push_i) begin
      ptr_q <= ptr_q + cps_pkg::SP_ONE;
      if (cnt_q != cps_pkg::STK_FULL) begin
        cnt_q <= cnt_q + cps_pkg::CNT_ONE;
      end
    end else if (pop_i) begin
      ptr_q <= ptr_q - cps_pkg::SP_ONE;
      if (cnt_q != '0) begin
        cnt_q <= cnt_q - cps_pkg::CNT_ONE;
      end
    end
  end

  assign top_o  = mem_q[ptr_q - cps_pkg::SP_ONE];
  assign full_o = (cnt_q == cps_pkg::STK_FULL);

  stack_ovf_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (push_i && full_o) |=> full_o && top_o == $past(d_i))
    else $error("overflowing push lost fullness or data");
  push_top_a: assert property (@(posedge clk_i) disable iff (rst_i)
    push_i ##8 pop_i |=> top_o == $past(top_o, 9))
    else $error("pop did not restore previous top");
endmodule : cps_stack

// file: sim/cps_pmem.sv
// program memory model holding the test program
`timescale 1ns/1ps
module cps_pmem (
  input  wire logic [cps_pkg::PC_W-1:0] addr_i,
  output logic      [cps_pkg::IW-1:0]   data_o
);
  // fixed image; never calls with the stack full
  always_comb begin
    case (addr_i)
      12'h000: data_o = 16'h2F3C;
      12'h001: data_o = 16'h20C4;
      12'h002: data_o = 16'h6020;
      12'h003: data_o = 16'h4130;
      12'h004: data_o = 16'h2F99;
      12'h005: data_o = 16'h8001;
      12'h020: data_o = 16'h27FF;
      12'h021: data_o = 16'hAD00;
      12'h022: data_o = 16'h2F55;
      12'h023: data_o = 16'h8000;
      12'h130: data_o = 16'h2680;
      12'h131: data_o = 16'h4131;
      12'h140: data_o = 16'h2F11;
      12'h141: data_o = 16'h4141;
      default: data_o = 16'h0000;
    endcase
  end
endmodule : cps_pmem

// file: sim/testbench.sv
// self-checking bench: wishbone tasks, program run, page jump, interrupt
`timescale 1ns/1ps
module testbench;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [15:0] pm_data;
  logic [11:0] pm_addr;
  logic        pm_rd;
  logic        int_req;
  logic        int_ack;
  logic [3:0]  phase;
  logic [1:0]  osc;
  logic [31:0] rd;
  logic [3:0]  prev;
  int          n_errors;
  int          tests_run;

  cps_seq uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .pm_data_i(pm_data), .pm_addr_o(pm_addr), .pm_rd_o(pm_rd),
    .int_req_i(int_req), .int_ack_o(int_ack), .phase_o(phase), .osc_sel_o(osc));
  cps_pmem pmem (.addr_i(pm_addr), .data_o(pm_data));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_i);
    end
    if (n >= 50) check("ack wait", 32'h0000_0000, 32'h0000_0001);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic wait_addr(input logic [11:0] a);
    for (int i = 0; i < 40 && pm_addr !== a; i++) @(posedge clk_i);
  endtask : wait_addr

  task automatic summarize;
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  initial begin
    #(20000 * 5);
    n_errors++;
    summarize();
  end

  initial begin
    n_errors = 0;
    tests_run = 0;
    rst_i = 1'b1;
    {cyc, stb, we, int_req} = 4'h0;
    adr = 8'h00;
    sel = 4'h1;
    wdat = 32'h0000_0000;
    repeat (3) @(posedge clk_i);
    #1;
    check("phase rst", {28'h0, phase}, 32'h0000_0001);
    check("osc rst", {30'h0, osc}, 32'h0000_0002);
    check("fetch rst", {20'h0, pm_addr}, 32'h0000_0000);
    rst_i <= 1'b0;
    repeat (8) begin
      prev = phase;
      @(posedge clk_i);
      #1;
      check("phase", {28'h0, phase}, {28'h0, prev[2:0], prev[3]});
      check("pm rd", {31'h0, pm_rd}, {31'h0, phase[1]});
    end
    repeat (300) @(posedge clk_i);
    // call, skip, return, far jump; acc 3c+c4=00 then ff, skip on zero, or 80
    wait_addr(12'h131);
    check("loop addr", {20'h0, pm_addr}, 32'h0000_0131);
    wb(1'b0, 8'h04, 32'h0);
    check("acc", rd, 32'h0000_0080);
    wb(1'b0, 8'h08, 32'h0);
    check("status", rd, 32'h0000_0003);
    wb(1'b0, 8'h20, 32'h0);
    check("unmapped", rd, 32'h0000_0000);
    wb(1'b1, 8'h0C, 32'h0000_0004);
    wb(1'b0, 8'h10, 32'h0);
    check("indirect", rd, 32'h0000_0080);
    wb(1'b1, 8'h00, 32'h0000_0040);
    repeat (60) @(posedge clk_i);
    wait_addr(12'h141);
    check("page jump", {20'h0, pm_addr}, 32'h0000_0141);
    wb(1'b0, 8'h04, 32'h0);
    check("acc pcl", rd, 32'h0000_0011);
    wb(1'b1, 8'h14, 32'h0000_0007);
    @(posedge clk_i);
    #1;
    check("osc", {30'h0, osc}, 32'h0000_0003);
    int_req <= 1'b1;
    @(posedge clk_i);
    int_req <= 1'b0;
    for (int i = 0; i < 40 && int_ack !== 1'b1; i++) @(posedge clk_i);
    check("int ack", {31'h0, int_ack}, 32'h0000_0001);
    repeat (80) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0);
    check("isr acc", rd, 32'h0000_0099);
    wb(1'b0, 8'h14, 32'h0);
    check("ctrl after interrupt_return", rd, 32'h0000_0007);
    wait_addr(12'h141);
    check("back in loop", {20'h0, pm_addr}, 32'h0000_0141);
    summarize();
  end
endmodule : testbench
